// ### core/cgsoc_pkg.sv
// cgsoc_pkg: constants, field positions and carrier types of the clock
// generator control block; shared by the top and the serial slave.
package cgsoc_pkg;
  // serial protocol
  localparam logic [7:0] SLAVE_ADDR = 8'hD2;
  localparam logic [7:0] CMD_CODE = 8'h00;
  localparam logic [7:0] COUNT_MIN = 8'h01;
  localparam logic [7:0] COUNT_MAX = 8'h20;
  localparam logic [3:0] BITS_BYTE = 4'h8;
  localparam logic [3:0] BITS_ACK = 4'h9;
  localparam int NUM_CFG = 4;
  localparam logic [5:0] NUM_CFG_W = 6'h04;
  // configuration byte offsets
  localparam logic [5:0] OFS_CTRL = 6'h00;
  localparam logic [5:0] OFS_PROC = 6'h01;
  localparam logic [5:0] OFS_BUS = 6'h02;
  localparam logic [5:0] OFS_FIX = 6'h03;
  // power-up values; bit 0 of byte 0 is a constant one, not stored
  localparam logic [7:0] RST_CTRL = 8'h00;
  localparam logic [7:0] RST_PROC = 8'h07;
  localparam logic [7:0] RST_BUS = 8'h7F;
  localparam logic [7:0] RST_FIX = 8'hC7;
  // writable bits per byte
  localparam logic [7:0] WM_CTRL = 8'hA8;
  localparam logic [7:0] WM_PROC = 8'h7F;
  localparam logic [7:0] WM_BUS = 8'h7F;
  localparam logic [7:0] WM_FIX = 8'hFF;
  // byte 0 fields
  localparam int B0_SPREAD = 7;
  localparam int B0_SEL48 = 5;
  localparam int B0_CPUSTOP = 4;
  localparam int B0_MODE = 2;
  localparam int B0_FREQ = 1;
  localparam int B0_ONE = 0;
  // byte 1 fields
  localparam int B1_TRI = 6;
  localparam int B1_FREE0 = 4;
  localparam int B1_EN0 = 1;
  // byte 2/3 fields
  localparam int B2_EN0 = 1;
  localparam int B3_DOT = 7;
  localparam int B3_USB = 6;
  localparam int B3_STOP0 = 3;
  localparam int B3_EN0 = 0;

  // pins from outside the clock domain
  typedef struct packed {
    logic scl;
    logic sda;
    logic power_down_n;
    logic cpu_stop_n;
    logic bus_stop_n;
    logic power_good_strobe_n;
    logic mode_hi;
    logic mode_mid;
    logic frequency_select_strap;
    logic external_66_input;
    logic test_clock_input;
    logic pll_cpu;
    logic pll_66;
    logic pll_48;
    logic pll_33;
    logic crystal_input;
  } cgsoc_pins_t;
  // pin levels held in reset: lines released, strobe and stops inactive
  localparam cgsoc_pins_t PINS_IDLE = '{scl: 1'b1, sda: 1'b1, power_down_n: 1'b1, cpu_stop_n: 1'b1,
    bus_stop_n: 1'b1, power_good_strobe_n: 1'b1, default: 1'b0};

  // one accepted data byte
  typedef struct packed {
    logic valid;
    logic [5:0] index;
    logic [7:0] data;
  } cgsoc_wr_t;

  // gated clock outputs and analog controls
  typedef struct packed {
    logic [1:0] cpu_t;
    logic [1:0] cpu_c;
    logic [1:0] drive_t;
    logic [1:0] drive_c;
    logic [1:0] park_dbl_ref;
    logic [5:0] bus;
    logic [2:0] bus_free;
    logic [1:0] clock_66_output;
    logic [2:0] buffered_66_output;
    logic usb;
    logic dot;
    logic reference_clock_output;
    logic osc_run;
    logic spread_on;
    logic freq_133;
  } cgsoc_outs_t;
endpackage

// ### core/cgsoc_smbus_slave.sv
// cgsoc_smbus_slave: write-only serial slave taking block writes.
// assumes scl_s and sda_s are already synchronised to clk.
`timescale 1ns/1ps
module cgsoc_smbus_slave (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // synchronised serial lines
  input wire logic scl_s,
  input wire logic sda_s,
  // open-drain data pull-down enable
  output logic sda_oe,
  // accepted data bytes
  output cgsoc_pkg::cgsoc_wr_t wr
);
  typedef enum logic [2:0] {SM_IDLE, SM_ADDR, SM_CMD, SM_COUNT, SM_DATA, SM_SKIP} cgsoc_sm_t;
  cgsoc_sm_t st_r, st_nxt;
  logic [3:0] bit_r, bit_nxt;
  logic [7:0] sh_r, sh_nxt;
  logic [5:0] cnt_r, cnt_nxt;
  logic [5:0] idx_r, idx_nxt;
  logic ack_r, ack_nxt;
  logic scl_p_r, sda_p_r;
  cgsoc_pkg::cgsoc_wr_t wr_r, wr_nxt;
  logic scl_rise, scl_fall, start_c, stop_c;

  // line events, decoded in the same cycle from the synchroniser output and its previous value
  assign scl_rise = scl_s & ~scl_p_r;
  assign scl_fall = ~scl_s & scl_p_r;
  assign start_c = scl_s & scl_p_r & sda_p_r & ~sda_s;
  assign stop_c = scl_s & scl_p_r & ~sda_p_r & sda_s;

  // byte engine: shift on rise, ack decided on the eighth fall
  always_comb begin
    st_nxt = st_r;
    bit_nxt = bit_r;
    sh_nxt = sh_r;
    cnt_nxt = cnt_r;
    idx_nxt = idx_r;
    ack_nxt = ack_r;
    wr_nxt = '0;
    if (start_c) begin
      st_nxt = SM_ADDR;
      bit_nxt = 4'h0;
      ack_nxt = 1'b0;
    end else if (stop_c) begin
      st_nxt = SM_IDLE;
      ack_nxt = 1'b0;
    end else if (st_r != SM_IDLE && st_r != SM_SKIP) begin
      if (scl_rise) begin
        if (bit_r < cgsoc_pkg::BITS_BYTE) begin
          sh_nxt = {sh_r[6:0], sda_s}; // RQ6
        end
        bit_nxt = bit_r + 4'h1;
        // byte is kept once the host has clocked our ack
        if (bit_r == cgsoc_pkg::BITS_BYTE && ack_r && st_r == SM_DATA) begin
          wr_nxt.valid = 1'b1; // RQ7
          wr_nxt.index = idx_r; // RQ6
          wr_nxt.data = sh_r;
        end
      end else if (scl_fall && bit_r == cgsoc_pkg::BITS_BYTE) begin
        unique case (st_r)
          SM_ADDR: ack_nxt = (sh_r == cgsoc_pkg::SLAVE_ADDR); // RQ1 RQ3
          SM_CMD: ack_nxt = (sh_r == cgsoc_pkg::CMD_CODE); // RQ2
          SM_COUNT: ack_nxt = (sh_r >= cgsoc_pkg::COUNT_MIN) && (sh_r <= cgsoc_pkg::COUNT_MAX);
          default: ack_nxt = (idx_r < cnt_r);
        endcase
      end else if (scl_fall && bit_r == cgsoc_pkg::BITS_ACK) begin
        ack_nxt = 1'b0;
        bit_nxt = 4'h0;
        if (!ack_r) begin
          st_nxt = SM_SKIP; // refused byte ends our part in the frame
        end else begin
          unique case (st_r)
            SM_ADDR: st_nxt = SM_CMD;
            SM_CMD: st_nxt = SM_COUNT;
            SM_COUNT: begin
              st_nxt = SM_DATA; // RQ7
              cnt_nxt = sh_r[5:0];
              idx_nxt = 6'h00;
            end
            default: idx_nxt = idx_r + 6'h01; // RQ6
          endcase
        end
      end
    end
  end

  // state registers
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st_r <= SM_IDLE;
      bit_r <= 4'h0;
      sh_r <= 8'h00;
      cnt_r <= 6'h00;
      idx_r <= 6'h00;
      ack_r <= 1'b0;
      scl_p_r <= 1'b1;
      sda_p_r <= 1'b1;
      wr_r <= '0;
    end else begin
      st_r <= st_nxt;
      bit_r <= bit_nxt;
      sh_r <= sh_nxt;
      cnt_r <= cnt_nxt;
      idx_r <= idx_nxt;
      ack_r <= ack_nxt;
      scl_p_r <= scl_s;
      sda_p_r <= sda_s;
      wr_r <= wr_nxt;
    end
  end

  assign sda_oe = ack_r;
  assign wr = wr_r;

  // only the documented write address is acknowledged
  addr_ack_a: assert property (@(posedge clk) disable iff (!nrst) // RQ1
    (st_r == SM_ADDR && $rose(ack_r)) |-> sh_r == cgsoc_pkg::SLAVE_ADDR)
    else $error("address other than D2 acknowledged");
  // data bytes only after an acknowledged count
  data_after_count_a: assert property (@(posedge clk) disable iff (!nrst) // RQ7
    wr_r.valid |-> $past(st_r) == SM_DATA && $past(ack_r) && wr_r.index < cnt_r)
    else $error("data byte stored outside a counted block");
  cov_addr: cover property (@(posedge clk) disable iff (!nrst) st_r == SM_ADDR ##[1:400] st_r == SM_CMD);
  cov_write: cover property (@(posedge clk) disable iff (!nrst) wr_r.valid);
endmodule

// ### core/cgsoc_top.sv
// cgsoc_top: control of the clock synthesizer: serial configuration bytes,
// strap latching and gating of every output clock.
// assumes the synthesizer clock sources and all pins are asynchronous to clk.
// Notes on behaviour
// (RQ1) slave answers only write address D2
// (RQ2) block writes only, no indexed access
// (RQ3) zero direction bit means write
// (RQ4) host sends zero command, then count
// (RQ5) count is one to thirty-two bytes
// (RQ6) bytes MSB first, ascending from zero
// (RQ7) acked count makes transfer valid
// (RQ8) bytes load defaults at power-up
// (RQ9) power-down parks outputs, stops oscillator
// (RQ10) processor stop parks stoppable processor pairs
// (RQ11) bus stop halts six ordinary bus clocks
// (RQ12) byte1 bits5,4 make pairs free running
// (RQ13) byte1 bit6 three-states pairs in power-down
// (RQ14) byte1 bits2,1 enable processor pairs
// (RQ15) byte2 bits6..1 enable bus clocks
// (RQ16) byte3 enables 48MHz and free bus clocks
// (RQ17) byte3 bits5..3 let free clocks stop
// (RQ18) byte0 bit7 turns down-spread on
// (RQ19) byte0 bit5 picks 48 MHz shared output
// (RQ20) byte0 shows live stop and latched straps
// (RQ21) straps latched once; later strobe ignored
// (RQ22) straps pick frequency and external 66 input
// (RQ23) test mode divides the test clock
// (RQ24) read-only bits kept, extra bytes dropped
`timescale 1ns/1ps
module cgsoc_top (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // serial management pins
  input wire logic scl,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  // power management pins
  input wire logic power_down_n,
  input wire logic cpu_stop_n,
  input wire logic bus_stop_n,
  input wire logic power_good_strobe_n,
  // straps; the three-level mode strap arrives as two comparator levels
  input wire logic mode_hi,
  input wire logic mode_mid,
  input wire logic frequency_select_strap,
  // clock sources
  input wire logic external_66_input,
  input wire logic crystal_input,
  input wire logic pll_cpu,
  input wire logic pll_66,
  input wire logic pll_48,
  input wire logic pll_33,
  // gated outputs and status
  output cgsoc_pkg::cgsoc_outs_t outs,
  output logic [7:0] control_status_byte
);
  cgsoc_pkg::cgsoc_pins_t pins_raw, s1_r, s2_r, pins_p_r;
  cgsoc_pkg::cgsoc_wr_t wr;
  cgsoc_pkg::cgsoc_outs_t outs_r, outs_nxt;
  logic [3:0][7:0] cfg_r, cfg_nxt;
  logic [2:0] straps_r, straps_nxt;
  logic latched_r, latched_nxt;
  logic [2:0] tdiv_r, tdiv_nxt;
  logic ext_half_r, ext_half_nxt;
  logic pd, cpu_stop, bus_stop, test_mode, ext_mode;
  logic src_cpu, src_66, src_48, src_bus, src_ref;

  // write mask per configuration byte, used by the masked write merge
  function automatic logic [7:0] wmask(input logic [5:0] idx);
    unique case (idx)
      cgsoc_pkg::OFS_CTRL: wmask = cgsoc_pkg::WM_CTRL;
      cgsoc_pkg::OFS_PROC: wmask = cgsoc_pkg::WM_PROC;
      cgsoc_pkg::OFS_BUS: wmask = cgsoc_pkg::WM_BUS;
      default: wmask = cgsoc_pkg::WM_FIX;
    endcase
  endfunction

  // every pin and source clock crosses through two flops
  assign pins_raw = '{scl: scl, sda: sda_in, power_down_n: power_down_n, cpu_stop_n: cpu_stop_n,
    bus_stop_n: bus_stop_n, power_good_strobe_n: power_good_strobe_n, mode_hi: mode_hi,
    mode_mid: mode_mid, frequency_select_strap: frequency_select_strap,
    external_66_input: external_66_input, test_clock_input: crystal_input, pll_cpu: pll_cpu,
    pll_66: pll_66, pll_48: pll_48, pll_33: pll_33, crystal_input: crystal_input};

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s1_r <= cgsoc_pkg::PINS_IDLE; // an all-zero reset would look like a strobe and latch at once
      s2_r <= cgsoc_pkg::PINS_IDLE;
      pins_p_r <= cgsoc_pkg::PINS_IDLE;
    end else begin
      s1_r <= pins_raw;
      s2_r <= s1_r;
      pins_p_r <= s2_r;
    end
  end

  cgsoc_smbus_slave u_slave (
    .clk(clk),
    .nrst(nrst),
    .scl_s(s2_r.scl),
    .sda_s(s2_r.sda),
    .sda_oe(sda_oe),
    .wr(wr)
  );
  assign sda_out = 1'b0;

  // configuration bytes: masked merge; bytes past the last are dropped
  always_comb begin
    cfg_nxt = cfg_r;
    if (wr.valid && wr.index < cgsoc_pkg::NUM_CFG_W) begin // RQ24
      cfg_nxt[wr.index[1:0]] = (cfg_r[wr.index[1:0]] & ~wmask(wr.index))
        | (wr.data & wmask(wr.index)); // RQ24
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cfg_r[cgsoc_pkg::OFS_CTRL[1:0]] <= cgsoc_pkg::RST_CTRL; // RQ8
      cfg_r[cgsoc_pkg::OFS_PROC[1:0]] <= cgsoc_pkg::RST_PROC;
      cfg_r[cgsoc_pkg::OFS_BUS[1:0]] <= cgsoc_pkg::RST_BUS;
      cfg_r[cgsoc_pkg::OFS_FIX[1:0]] <= cgsoc_pkg::RST_FIX;
    end else begin
      cfg_r <= cfg_nxt;
    end
  end

  // straps follow the pins until the strobe is first seen low, then freeze
  always_comb begin
    straps_nxt = straps_r;
    latched_nxt = latched_r;
    if (!latched_r) begin
      straps_nxt = {s2_r.mode_hi, s2_r.mode_mid, s2_r.frequency_select_strap}; // RQ21
      latched_nxt = ~s2_r.power_good_strobe_n; // RQ21
    end
  end

  // test clock divider: edge count of the sampled test clock
  always_comb begin
    tdiv_nxt = tdiv_r;
    ext_half_nxt = ext_half_r;
    if (s2_r.test_clock_input && !pins_p_r.test_clock_input) begin
      tdiv_nxt = tdiv_r + 3'h1; // RQ23
    end
    if (s2_r.external_66_input && !pins_p_r.external_66_input) begin
      ext_half_nxt = ~ext_half_r; // RQ22
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      straps_r <= 3'h0;
      latched_r <= 1'b0;
      tdiv_r <= 3'h0;
      ext_half_r <= 1'b0;
    end else begin
      straps_r <= straps_nxt;
      latched_r <= latched_nxt;
      tdiv_r <= tdiv_nxt;
      ext_half_r <= ext_half_nxt;
    end
  end

  // source selection by the latched straps
  assign pd = ~s2_r.power_down_n;
  assign cpu_stop = ~s2_r.cpu_stop_n;
  assign bus_stop = ~s2_r.bus_stop_n;
  assign ext_mode = straps_r[2];
  assign test_mode = straps_r[1] & ~straps_r[2] & ~straps_r[0]; // RQ23
  assign src_cpu = test_mode ? tdiv_r[0] : s2_r.pll_cpu; // RQ23
  assign src_48 = test_mode ? tdiv_r[0] : s2_r.pll_48;
  assign src_66 = test_mode ? tdiv_r[1] : s2_r.pll_66;
  assign src_ref = test_mode ? s2_r.test_clock_input : s2_r.crystal_input;
  // bus clocks come from the external input halved in buffer mode
  assign src_bus = test_mode ? tdiv_r[2] : (ext_mode ? ext_half_r : s2_r.pll_33); // RQ22

  // output gating
  always_comb begin
    outs_nxt = '0;
    outs_nxt.osc_run = ~pd; // RQ9
    outs_nxt.spread_on = cfg_r[0][cgsoc_pkg::B0_SPREAD] & ~pd; // RQ18
    outs_nxt.freq_133 = straps_r[0]; // RQ22
    for (int i = 0; i < 2; i++) begin
      if (pd && cfg_r[1][cgsoc_pkg::B1_TRI]) begin
        outs_nxt.drive_t[i] = 1'b0; // RQ13
      end else if (pd || (cpu_stop && !cfg_r[1][cgsoc_pkg::B1_FREE0 + i])
          || !cfg_r[1][cgsoc_pkg::B1_EN0 + i]) begin
        // parked: true side sinks doubled reference, complement floats
        outs_nxt.drive_t[i] = 1'b1; // RQ9 RQ10 RQ12 RQ14
        outs_nxt.cpu_t[i] = 1'b1;
        outs_nxt.park_dbl_ref[i] = 1'b1;
      end else begin
        outs_nxt.drive_t[i] = 1'b1;
        outs_nxt.drive_c[i] = 1'b1;
        outs_nxt.cpu_t[i] = src_cpu;
        outs_nxt.cpu_c[i] = ~src_cpu;
      end
    end
    if (!pd) begin
      for (int i = 0; i < 6; i++) begin
        outs_nxt.bus[i] = src_bus & ~bus_stop & cfg_r[2][cgsoc_pkg::B2_EN0 + i]; // RQ11 RQ15
      end
      for (int i = 0; i < 3; i++) begin
        outs_nxt.bus_free[i] = src_bus & cfg_r[3][cgsoc_pkg::B3_EN0 + i] // RQ16
          & ~(bus_stop & cfg_r[3][cgsoc_pkg::B3_STOP0 + i]); // RQ17
      end
      outs_nxt.clock_66_output[0] = src_66;
      outs_nxt.clock_66_output[1] = cfg_r[0][cgsoc_pkg::B0_SEL48] ? src_48 : src_66; // RQ19
      outs_nxt.buffered_66_output = {3{ext_mode && !test_mode ? s2_r.external_66_input : src_66}}; // RQ22
      outs_nxt.usb = src_48 & cfg_r[3][cgsoc_pkg::B3_USB]; // RQ16
      outs_nxt.dot = src_48 & cfg_r[3][cgsoc_pkg::B3_DOT];
      outs_nxt.reference_clock_output = src_ref;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      outs_r <= '0;
    end else begin
      outs_r <= outs_nxt;
    end
  end

  assign outs = outs_r;
  // status view: live stop pin, latched straps, constant reserved one
  assign control_status_byte = {cfg_r[0][7], 1'b0, cfg_r[0][5], s2_r.cpu_stop_n, cfg_r[0][3],
    straps_r[2], straps_r[0], 1'b1}; // RQ20

  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  pd_all_low_a: assert property (pd |=> outs_r.bus == 6'h00 && outs_r.usb == 1'b0 // RQ9
    && outs_r.reference_clock_output == 1'b0 && !outs_r.osc_run && outs_r.drive_c == 2'b00)
    else $error("power-down left a clock running");
  pd_tristate_a: assert property (pd && cfg_r[1][cgsoc_pkg::B1_TRI] |=> outs_r.drive_t == 2'b00) // RQ13
    else $error("processor pairs driven in three-state power-down");
  cpu_stop_park_a: assert property (!pd && cpu_stop && !cfg_r[1][cgsoc_pkg::B1_FREE0] // RQ10
    |=> outs_r.park_dbl_ref[0] && !outs_r.drive_c[0])
    else $error("stoppable pair not parked");
  cpu_free_run_a: assert property (!pd && cfg_r[1][cgsoc_pkg::B1_FREE0 + 1] // RQ12
    && cfg_r[1][cgsoc_pkg::B1_EN0 + 1] |=> outs_r.drive_c[1])
    else $error("free-running pair stopped");
  bus_stop_a: assert property (bus_stop ##1 bus_stop |=> outs_r.bus == 6'h00) // RQ11
    else $error("bus clock ran during bus stop");
  free_stop_a: assert property (bus_stop && !cfg_r[3][cgsoc_pkg::B3_STOP0] // RQ17
    && !pd && cfg_r[3][cgsoc_pkg::B3_EN0] |=> outs_r.bus_free[0] == $past(src_bus))
    else $error("free-running bus clock gated");
  sel48_a: assert property (!pd && cfg_r[0][cgsoc_pkg::B0_SEL48] // RQ19
    |=> outs_r.clock_66_output[1] == $past(src_48))
    else $error("shared output not on 48 MHz");
  strap_freeze_a: assert property (latched_r |=> $stable(straps_r) && latched_r) // RQ21
    else $error("straps changed after latching");
  defaults_a: assert property ($rose(nrst) |-> cfg_r == {cgsoc_pkg::RST_FIX, // RQ8
    cgsoc_pkg::RST_BUS, cgsoc_pkg::RST_PROC, cgsoc_pkg::RST_CTRL})
    else $error("configuration bytes not at defaults");
  ro_bits_a: assert property (wr.valid && wr.index == cgsoc_pkg::OFS_CTRL // RQ24
    |=> control_status_byte[cgsoc_pkg::B0_ONE] && !control_status_byte[6]
    && cfg_r[0][cgsoc_pkg::B0_CPUSTOP] == $past(cfg_r[0][cgsoc_pkg::B0_CPUSTOP]))
    else $error("read-only status bit written");
  ext_buf_a: assert property (ext_mode && !test_mode && !pd // RQ22
    |=> outs_r.buffered_66_output == {3{$past(s2_r.external_66_input)}})
    else $error("buffered outputs not following the external input");
  test_ref_a: assert property (test_mode && !pd // RQ23
    |=> outs_r.reference_clock_output == $past(s2_r.test_clock_input))
    else $error("reference output not on the test clock");
  cov_pd: cover property ($fell(s2_r.power_down_n) ##1 pd [*4]);
  cov_cpu_stop: cover property (!pd && cpu_stop ##1 outs_r.park_dbl_ref != 2'b00);
  cov_test: cover property (test_mode && outs_r.bus != 6'h00);
endmodule

// ### tb/cgsoc_host.sv
// cgsoc_host: behavioural serial host that sends block write frames.
// assumes an open-drain data wire with a pull-up, resolved by the bench.
`timescale 1ns/1ps
module cgsoc_host (
  // clock
  input wire logic clk,
  // resolved data wire
  input wire logic sda_w,
  // serial clock and data pull-down
  output logic scl,
  output logic sda_pull
);
  // serial clock stands high between frames, data released
  initial begin
    scl = 1'b1;
    sda_pull = 1'b0;
  end

  task automatic tick(input int n);
    repeat (n) begin
      @(posedge clk);
      #1;
    end
  endtask

  // one bit: data set mid low phase, wire sampled mid high phase
  task automatic bit_out(input logic b, output logic s);
    scl = 1'b0;
    tick(2);
    sda_pull = !b;
    tick(2);
    scl = 1'b1;
    tick(2);
    s = sda_w;
    tick(2);
  endtask

  // eight data bits, then the acknowledge slot with data released
  task automatic byte_out(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_out(b[i], s);
    end
    bit_out(1'b1, s);
    ack = !s;
  endtask

  // start, bytes in order until a refusal, stop; caller supplies address,
  // command and count first, and they are sent as given, even when not a block write
  task automatic frame(input int n, input logic [7:0] b [0:39], output int acks);
    logic a;
    acks = 0;
    a = 1'b1;
    sda_pull = 1'b1;
    tick(4);
    for (int i = 0; i < n && a; i++) begin
      byte_out(b[i], a);
      if (a) acks++;
    end
    // a real host gives up on the first refused byte
    scl = 1'b0;
    tick(2);
    sda_pull = 1'b1;
    tick(2);
    scl = 1'b1;
    tick(4);
    sda_pull = 1'b0;
    tick(4);
  endtask
endmodule

// ### tb/tb.sv
// tb: self-checking bench of the clock generator control block.
// assumes the host model in cgsoc_host and static clock sources per check.
`timescale 1ns/1ps
module tb;
  logic clk, nrst, scl, host_pull, sda_out, sda_oe, sda_w;
  logic power_down_n, cpu_stop_n, bus_stop_n, power_good_strobe_n;
  logic mode_hi, mode_mid, frequency_select_strap;
  logic external_66_input, crystal_input, pll_cpu, pll_66, pll_48, pll_33;
  cgsoc_pkg::cgsoc_outs_t outs;
  logic [7:0] control_status_byte;
  logic [7:0] cfg [0:3];
  logic [7:0] wm [0:3];
  logic [7:0] fb [0:39];
  logic [31:0] r;
  logic fr_l, ext_l, eh, e66p;
  int seed, err_total, tests_run, n, k;

  // pull-up on the data wire; either party may pull it low
  assign sda_w = !(host_pull | sda_oe);

  cgsoc_host host (.clk(clk), .sda_w(sda_w), .scl(scl), .sda_pull(host_pull));

  cgsoc_top uut (.clk(clk), .nrst(nrst), .scl(scl), .sda_in(sda_w), .sda_out(sda_out), .sda_oe(sda_oe),
    .power_down_n(power_down_n), .cpu_stop_n(cpu_stop_n), .bus_stop_n(bus_stop_n),
    .power_good_strobe_n(power_good_strobe_n), .mode_hi(mode_hi), .mode_mid(mode_mid),
    .frequency_select_strap(frequency_select_strap), .external_66_input(external_66_input),
    .crystal_input(crystal_input), .pll_cpu(pll_cpu), .pll_66(pll_66), .pll_48(pll_48), .pll_33(pll_33),
    .outs(outs), .control_status_byte(control_status_byte));

  initial begin
    clk = 1'b0;
    forever #25 clk = !clk;
  end

  task automatic tick(input int c);
    repeat (c) begin
      @(posedge clk);
      #1;
    end
  endtask

  task automatic end_sim;
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    tests_run++;
    if (g !== e) begin
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
      err_total++;
    end
  endtask

  // reset, then latch the straps and move mode_hi and the frequency strap; the latch must not follow
  task automatic power_up(input logic hi, input logic mid);
    r = $random(seed);
    ext_l = hi;
    fr_l = r[0] & !mid; // test mode needs the frequency strap low
    eh = 1'b0;
    e66p = 1'b0;
    nrst = 1'b0;
    power_good_strobe_n = 1'b1;
    mode_hi = hi;
    mode_mid = mid;
    frequency_select_strap = fr_l;
    // source clocks low so no edge is counted as reset ends
    {external_66_input, crystal_input} = 2'h0;
    tick(10);
    nrst = 1'b1;
    cfg = '{cgsoc_pkg::RST_CTRL, cgsoc_pkg::RST_PROC, cgsoc_pkg::RST_BUS, cgsoc_pkg::RST_FIX};
    tick(4);
    power_good_strobe_n = 1'b0;
    tick(4);
    power_good_strobe_n = 1'b1;
    mode_hi = !hi;
    frequency_select_strap = !fr_l;
  endtask

  // sources held static so a running output shows its source level
  task automatic gate_chk;
    logic pd, cs, bs, p33, p48, p66, x, sb;
    logic [1:0] run, park, pc;
    r = $random(seed);
    {p33, p48, p66, x, cs, bs} = r[5:0];
    pd = r[7:6] != 2'h0;
    power_down_n = pd;
    cpu_stop_n = cs;
    bus_stop_n = bs;
    pll_33 = p33;
    pll_48 = p48;
    pll_66 = p66;
    crystal_input = x;
    pll_cpu = r[8];
    external_66_input = r[9];
    // the halved external clock toggles on every rise of its input
    eh = eh ^ (r[9] & !e66p);
    e66p = r[9];
    sb = ext_l ? eh : p33;
    pc = {2{r[8]}};
    tick(6);
    run = {2{pd}} & cfg[1][2:1] & ({2{cs}} | cfg[1][5:4]);
    park = ~run & {2{pd | !cfg[1][6]}};
    chk("bus", {2'h0, {6{pd & bs & sb}} & cfg[2][6:1]}, {2'h0, outs.bus});
    chk("bus_free", {5'h0, {3{pd & sb}} & cfg[3][2:0] & ~(cfg[3][5:3] & {3{!bs}})}, {5'h0, outs.bus_free});
    chk("usb_dot", {6'h0, {2{pd & p48}} & cfg[3][7:6]}, {6'h0, outs.dot, outs.usb});
    chk("c66", {6'h0, pd & (cfg[0][5] ? p48 : p66), pd & p66}, {6'h0, outs.clock_66_output});
    chk("buf66", {5'h0, {3{pd & (ext_l ? r[9] : p66)}}}, {5'h0, outs.buffered_66_output});
    chk("ref_osc", {6'h0, pd & x, pd}, {6'h0, outs.reference_clock_output, outs.osc_run});
    chk("cpu", {4'h0, run, park}, {4'h0, outs.drive_c, outs.park_dbl_ref});
    chk("cpu_tc", {2'h0, run | park, run & pc | park, run & ~pc}, {2'h0, outs.drive_t, outs.cpu_t, outs.cpu_c});
    chk("spr_frq", {6'h0, cfg[0][7] & pd, fr_l}, {6'h0, outs.spread_on, outs.freq_133});
    chk("status", {cfg[0][7], 1'h0, cfg[0][5], cs, cfg[0][3], ext_l, fr_l, 1'h1}, control_status_byte);
    chk("sda_idle", 8'h00, {6'h0, sda_out, sda_oe});
  endtask

  task automatic send(input int nb, input int ea);
    int a;
    host.frame(nb, fb, a);
    chk("acks", ea[7:0], a[7:0]);
  endtask

  // hang guard
  initial begin
    repeat (100000) @(posedge clk);
    err_total++;
    end_sim();
  end

  initial begin
    seed = 31;
    err_total = 0;
    tests_run = 0;
    mode_mid = 1'b0;
    power_down_n = 1'b1;
    cpu_stop_n = 1'b1;
    bus_stop_n = 1'b1;
    {external_66_input, crystal_input, pll_cpu, pll_66, pll_48, pll_33} = 6'h00;
    wm = '{cgsoc_pkg::WM_CTRL, cgsoc_pkg::WM_PROC, cgsoc_pkg::WM_BUS, cgsoc_pkg::WM_FIX};
    power_up(1'b0, 1'b0);
    repeat (8) gate_chk();
    $display("test defaults done");
    // random block writes; first one longest count with one byte too many
    for (int it = 0; it < 20; it++) begin
      r = $random(seed);
      n = (it == 0) ? 32 : 1 + r[7:0] % 6;
      k = (it == 0) ? 33 : 1 + r[15:8] % (n + 1);
      fb[0] = cgsoc_pkg::SLAVE_ADDR;
      fb[1] = cgsoc_pkg::CMD_CODE;
      fb[2] = n[7:0];
      for (int i = 0; i < k; i++) begin
        r = $random(seed);
        fb[i + 3] = r[7:0];
        if (i == 2) fb[i + 3][0] = 1'b0;
        if (i < n && i < 4) cfg[i] = (cfg[i] & ~wm[i]) | (fb[i + 3] & wm[i]);
      end
      send(k + 3, 3 + ((k < n) ? k : n));
      gate_chk();
    end
    $display("test block_writes done");
    // refused frames must leave every byte alone
    for (int t = 0; t < 5; t++) begin
      fb[0] = cgsoc_pkg::SLAVE_ADDR;
      fb[1] = cgsoc_pkg::CMD_CODE;
      fb[2] = 8'h01;
      fb[3] = 8'hFF;
      case (t)
        0: fb[0] = 8'hD3;
        1: fb[0] = 8'hD0;
        2: fb[1] = 8'h01;
        3: fb[2] = 8'h00;
        default: fb[2] = 8'h21;
      endcase
      send(4, (t < 2) ? 0 : ((t == 2) ? 1 : 2));
      gate_chk();
    end
    $display("test refusals done");
    // second reset latches the external-input mode
    power_up(1'b1, 1'b0);
    repeat (4) gate_chk();
    $display("test second_reset done");
    // test mode: step the test clock slowly, the divider counts its rises
    power_up(1'b0, 1'b1);
    {power_down_n, cpu_stop_n, bus_stop_n} = 3'h7;
    for (int j = 1; j <= 16; j++) begin
      crystal_input = j[0];
      tick(5);
      n = (j + 1) / 2;
      chk("test_div", {2'h0, n[2], n[1], n[0], ~n[0], n[0], j[0]}, {2'h0, outs.bus[5], outs.clock_66_output[0],
        outs.cpu_t[1], outs.cpu_c[0], outs.usb, outs.reference_clock_output});
    end
    $display("test test_mode done");
    end_sim();
  end
endmodule
